// ===== uart_pkg.sv
// constants, field positions and state types of the serial port
// assumes a single clock domain and word-aligned register access
`default_nettype none

package uart_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'hF6;
  localparam logic [7:0] DATA_IDX = 8'hF7;
  localparam logic [7:0] BAUD_IDX = 8'hF8;
  localparam logic [7:0] FLAG_IDX = 8'hF9;

  // control register fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RE_BIT = 4;
  localparam int TB8_BIT = 3;
  localparam int RB8_BIT = 2;
  localparam int RIE_BIT = 1;
  localparam int TIE_BIT = 0;

  // flag register fields
  localparam int RIP_BIT = 5;
  localparam int TIP_BIT = 4;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // mode field encodings
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;

  // bit timing in sixteenth-of-bit ticks
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] PH_CENTRE = 4'h7;

  // bits per transfer, index of last bit
  localparam logic [3:0] SYNC_LAST = 4'h7;
  localparam logic [3:0] ASYNC8_LAST = 4'h9;
  localparam logic [3:0] FIXED9_LAST = 4'hA;

  typedef enum logic [1:0] {T_IDLE, T_ASYNC, T_SYNC} tx_state_e;
  typedef enum logic {R_IDLE, R_RUN} rx_state_e;

endpackage

`default_nettype wire

// ===== uart_sync2.sv
// two-stage synchroniser for a pin input
// assumes the pin idles at the reset level given by the parameter
`default_nettype none

module uart_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pin and result
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_s;

  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= {RST_VAL, RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.sync;

endmodule

`default_nettype wire

// ===== uart_tick_gen.sv
// sixteen-times-bit-rate tick generator
// assumes divisor changes only while the port is idle
`default_nettype none

module uart_tick_gen #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // rate select
  input wire logic fixed_rate,
  input wire logic [DIV_W-1:0] divisor,
  // one-cycle tick
  output logic tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } tick_s;

  tick_s s;
  tick_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (fixed_rate) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else if (s.cnt >= divisor) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = DIV_W'(s.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

`default_nettype wire

// ===== uart_serial.sv
// serial port with synchronous, 8-bit async and 9-bit fixed-rate modes
// assumes an AHB-Lite master on the same clock, pins synchronised here
`default_nettype none

module uart_serial (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // serial pins
  input wire logic I_RXD,
  output logic O_RXD_OUT,
  output logic O_RXD_OE,
  output logic O_TXD,
  // receive interrupt request
  output logic O_SERIAL_RECEIVE_IRQ_LINE
);

  typedef struct packed {
    logic dp_wr;
    logic [7:0] dp_idx;
    logic [31:0] hrdata;
    logic [7:0] ctrl;
    logic [7:0] baud;
    logic receive_pending_flag;
    logic transmit_pending_flag;
    logic [7:0] rx_buf;
    uart_pkg::tx_state_e tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_idx;
    logic [3:0] tx_last;
    logic [3:0] tx_ph;
    logic sync_rx;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    uart_pkg::rx_state_e rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_idx;
    logic [3:0] rx_ph;
    logic rxd_prev;
    logic irq;
  } port_s;

  port_s s;
  port_s next_s;
  logic rxd_s;
  logic tick;
  logic [1:0] mode;
  logic take;
  logic data_wr;
  logic flag_wr;

  function automatic logic [31:0] read_word(input port_s r,
                                            input logic [7:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      uart_pkg::CTRL_IDX: w[7:0] = r.ctrl;
      uart_pkg::DATA_IDX: w[7:0] = r.rx_buf;
      uart_pkg::BAUD_IDX: w[7:0] = r.baud;
      uart_pkg::FLAG_IDX: begin
        w[uart_pkg::RIP_BIT] = r.receive_pending_flag;
        w[uart_pkg::TIP_BIT] = r.transmit_pending_flag;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic [3:0] last_bit(input logic [1:0] m);
    logic [3:0] n;
    n = uart_pkg::ASYNC8_LAST;
    if (m == uart_pkg::MODE_FIXED9) begin
      n = uart_pkg::FIXED9_LAST;
    end
    return n;
  endfunction

  uart_sync2 #(
    .RST_VAL(1'b1)
  ) u_rxd_sync (
    .clk(I_REF_CLK),
    .arst_n(I_ARST_N),
    .d(I_RXD),
    .q(rxd_s)
  );

  uart_tick_gen #(
    .DIV_W(8)
  ) u_tick (
    .clk(I_REF_CLK),
    .arst_n(I_ARST_N),
    .fixed_rate(mode == uart_pkg::MODE_FIXED9),
    .divisor(s.baud),
    .tick(tick)
  );

  assign mode = s.ctrl[uart_pkg::MODE_HI:uart_pkg::MODE_LO];
  assign take = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign data_wr = s.dp_wr & (s.dp_idx == uart_pkg::DATA_IDX);
  assign flag_wr = s.dp_wr & (s.dp_idx == uart_pkg::FLAG_IDX);

  always_comb begin
    next_s = s;
    next_s.dp_wr = 1'b0;
    next_s.rxd_prev = rxd_s;

    // bus address phase
    if (take) begin
      next_s.dp_wr = I_HWRITE;
      next_s.dp_idx = I_HADDR[9:2];
      if (!I_HWRITE) begin
        next_s.hrdata = read_word(s, I_HADDR[9:2]);
      end
    end

    // bus data phase writes
    if (s.dp_wr) begin
      case (s.dp_idx)
        uart_pkg::CTRL_IDX: next_s.ctrl = I_HWDATA[7:0];
        uart_pkg::BAUD_IDX: next_s.baud = I_HWDATA[7:0];
        default: next_s.baud = s.baud;
      endcase
    end
    if (flag_wr && !I_HWDATA[uart_pkg::RIP_BIT]) begin
      next_s.receive_pending_flag = 1'b0;
    end
    if (flag_wr && !I_HWDATA[uart_pkg::TIP_BIT]) begin
      next_s.transmit_pending_flag = 1'b0;
    end

    // transmitter and synchronous shifter
    case (s.tx_st)
      uart_pkg::T_IDLE: begin
        next_s.txd = 1'b1;
        next_s.rxd_oe = 1'b0;
        if (data_wr && mode == uart_pkg::MODE_SYNC) begin
          next_s.tx_st = uart_pkg::T_SYNC;
          next_s.sync_rx = 1'b0;
          next_s.tx_sh = {3'h0, I_HWDATA[7:0]};
          next_s.tx_idx = 4'h0;
          next_s.tx_ph = 4'h0;
          next_s.txd = 1'b0;
          next_s.rxd_out = I_HWDATA[0];
          next_s.rxd_oe = 1'b1;
        end else if (data_wr && (mode == uart_pkg::MODE_ASYNC8 ||
                                 mode == uart_pkg::MODE_FIXED9)) begin
          next_s.tx_st = uart_pkg::T_ASYNC;
          next_s.tx_sh[0] = 1'b0;
          next_s.tx_sh[8:1] = I_HWDATA[7:0];
          next_s.tx_sh[9] = (mode == uart_pkg::MODE_FIXED9) ?
                            s.ctrl[uart_pkg::TB8_BIT] : 1'b1;
          next_s.tx_sh[10] = 1'b1;
          next_s.tx_last = last_bit(mode);
          next_s.tx_idx = 4'h0;
          next_s.tx_ph = 4'h0;
          next_s.txd = 1'b0;
        end else if (mode == uart_pkg::MODE_SYNC &&
                     s.ctrl[uart_pkg::RE_BIT] && !s.receive_pending_flag &&
                     !flag_wr && !data_wr) begin
          next_s.tx_st = uart_pkg::T_SYNC;
          next_s.sync_rx = 1'b1;
          next_s.tx_sh = 11'h000;
          next_s.tx_idx = 4'h0;
          next_s.tx_ph = 4'h0;
          next_s.txd = 1'b0;
        end
      end
      uart_pkg::T_ASYNC: begin
        if (tick) begin
          if (s.tx_ph == uart_pkg::PH_LAST) begin
            next_s.tx_ph = 4'h0;
            if (s.tx_idx == s.tx_last) begin
              next_s.tx_st = uart_pkg::T_IDLE;
              next_s.txd = 1'b1;
            end else begin
              next_s.tx_idx = 4'(s.tx_idx + 1'b1);
              next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
              next_s.txd = s.tx_sh[1];
              if (4'(s.tx_idx + 1'b1) == s.tx_last) begin
                next_s.transmit_pending_flag = 1'b1;
              end
            end
          end else begin
            next_s.tx_ph = 4'(s.tx_ph + 1'b1);
          end
        end
      end
      uart_pkg::T_SYNC: begin
        if (tick) begin
          next_s.tx_ph = 4'(s.tx_ph + 1'b1);
          if (s.tx_ph == uart_pkg::PH_CENTRE) begin
            next_s.txd = 1'b1;
            if (s.sync_rx) begin
              next_s.tx_sh[7:0] = {rxd_s, s.tx_sh[7:1]};
            end
          end
          if (s.tx_ph == uart_pkg::PH_LAST) begin
            next_s.tx_ph = 4'h0;
            if (s.tx_idx == uart_pkg::SYNC_LAST) begin
              next_s.tx_st = uart_pkg::T_IDLE;
              next_s.txd = 1'b1;
              next_s.rxd_oe = 1'b0;
              if (s.sync_rx) begin
                next_s.receive_pending_flag = 1'b1;
                next_s.rx_buf = s.tx_sh[7:0];
              end else begin
                next_s.transmit_pending_flag = 1'b1;
              end
            end else begin
              next_s.tx_idx = 4'(s.tx_idx + 1'b1);
              next_s.txd = 1'b0;
              if (!s.sync_rx) begin
                next_s.tx_sh = {1'b0, s.tx_sh[10:1]};
                next_s.rxd_out = s.tx_sh[1];
              end
            end
          end
        end
      end
      default: begin
        next_s.tx_st = uart_pkg::T_IDLE;
      end
    endcase

    // asynchronous receiver
    case (s.rx_st)
      uart_pkg::R_IDLE: begin
        if (s.ctrl[uart_pkg::RE_BIT] && s.rxd_prev && !rxd_s &&
            (mode == uart_pkg::MODE_ASYNC8 ||
             mode == uart_pkg::MODE_FIXED9)) begin
          next_s.rx_st = uart_pkg::R_RUN;
          next_s.rx_idx = 4'h0;
          next_s.rx_ph = 4'h0;
        end
      end
      uart_pkg::R_RUN: begin
        if (tick) begin
          next_s.rx_ph = 4'(s.rx_ph + 1'b1);
          if (s.rx_ph == uart_pkg::PH_CENTRE) begin
            next_s.rx_idx = 4'(s.rx_idx + 1'b1);
            if (s.rx_idx == 4'h0) begin
              if (rxd_s) begin
                next_s.rx_st = uart_pkg::R_IDLE;
              end
            end else if (s.rx_idx == last_bit(mode)) begin
              next_s.rx_st = uart_pkg::R_IDLE;
              next_s.receive_pending_flag = 1'b1;
              if (mode == uart_pkg::MODE_FIXED9) begin
                next_s.rx_buf = s.rx_sh[7:0];
                next_s.ctrl[uart_pkg::RB8_BIT] = s.rx_sh[8];
              end else begin
                next_s.rx_buf = s.rx_sh[8:1];
                next_s.ctrl[uart_pkg::RB8_BIT] = rxd_s;
              end
            end else begin
              next_s.rx_sh = {s.rx_sh[7:0], 1'b0};
              next_s.rx_sh[8:0] = {rxd_s, s.rx_sh[8:1]};
            end
          end
        end
        if (mode != uart_pkg::MODE_ASYNC8 &&
            mode != uart_pkg::MODE_FIXED9) begin
          next_s.rx_st = uart_pkg::R_IDLE;
        end
      end
      default: begin
        next_s.rx_st = uart_pkg::R_IDLE;
      end
    endcase

    next_s.irq = next_s.receive_pending_flag & next_s.ctrl[uart_pkg::RIE_BIT];
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s <= '0;
      s.ctrl <= uart_pkg::CTRL_RST;
      s.baud <= uart_pkg::BAUD_RST;
      s.tx_st <= uart_pkg::T_IDLE;
      s.rx_st <= uart_pkg::R_IDLE;
      s.txd <= 1'b1;
      s.rxd_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ready held in a flop of its own, response tied to okay
  logic hready;
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hready <= 1'b0;
    end else begin
      hready <= 1'b1;
    end
  end

  assign O_HRDATA = s.hrdata;
  assign O_HREADYOUT = hready;
  assign O_HRESP = 1'b0;
  assign O_TXD = s.txd;
  assign O_RXD_OUT = s.rxd_out;
  assign O_RXD_OE = s.rxd_oe;
  assign O_SERIAL_RECEIVE_IRQ_LINE = s.irq;

endmodule

`default_nettype wire

// ===== uart_serial_assertions.sv
// port checker for the serial port
// assumes single word transfers, one bus master
`default_nettype none

module uart_serial_chk (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  // bus
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HRESP,
  // pins
  input wire logic O_RXD_OE,
  input wire logic O_TXD,
  input wire logic O_SERIAL_RECEIVE_IRQ_LINE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wph;
  logic [7:0] widx;
  logic [7:0] ctl;
  logic [7:0] baud;
  logic dwr;
  logic [1:0] mode;
  assign dwr = wph && (widx == uart_pkg::DATA_IDX);
  assign mode = ctl[7:6];
  // shadow of written control and divisor
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wph <= 1'b0;
      widx <= 8'h00;
      ctl <= 8'h00;
      baud <= 8'h00;
    end else begin
      wph <= I_HSEL && I_HTRANS[1] && I_HWRITE && I_HREADY;
      widx <= I_HADDR[9:2];
      if (wph && widx == uart_pkg::CTRL_IDX) ctl <= I_HWDATA[7:0];
      if (wph && widx == uart_pkg::BAUD_IDX) baud <= I_HWDATA[7:0];
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_bit16;
    (!O_TXD)[*8] ##1 (!O_TXD)[*8];
  endsequence
  sequence s_sync_low;
    (!O_TXD)[*8] ##1 O_TXD;
  endsequence
  chk_resp_okay: assert property (!O_HRESP)
    else $error("bus response not okay");
  chk_rdata_upper: assert property (O_HRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_irq_masked: assert property (!ctl[uart_pkg::RIE_BIT] &&
    !$past(ctl[uart_pkg::RIE_BIT]) |-> !O_SERIAL_RECEIVE_IRQ_LINE)
    else $error("irq with enable clear");
  chk_oe_async: assert property (mode != 2'h0 &&
    $past(mode) != 2'h0 |-> !O_RXD_OE)
    else $error("data pin driven in async mode");
  chk_tx_start: assert property (dwr && mode != 2'h3 |->
    ##[1:3] !O_TXD) else $error("no start after data write");
  chk_sync_drive: assert property (dwr && mode == 2'h0 |->
    ##[1:3] O_RXD_OE) else $error("sync data not driven");
  chk_fixed_bit: assert property ($fell(O_TXD) && mode == 2'h2
    |-> s_bit16) else $error("fixed rate bit not 16 clocks");
  chk_sync_clock: assert property ($fell(O_TXD) && mode == 2'h0
    && baud == 8'h00 |-> s_sync_low) else $error("shift clock shape");
endmodule

bind uart_serial uart_serial_chk uart_serial_chk_inst (
  .I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_HSEL(I_HSEL),
  .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
  .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
  .O_HRESP(O_HRESP), .O_RXD_OE(O_RXD_OE), .O_TXD(O_TXD),
  .O_SERIAL_RECEIVE_IRQ_LINE(O_SERIAL_RECEIVE_IRQ_LINE)
);

`default_nettype wire

// ===== uart_remote.sv
// remote serial device on the data pin
// assumes a pull-up on the line, clock from the bench
`default_nettype none

module uart_remote (
  // clock and shift clock pin
  input wire logic i_clk,
  input wire logic i_sclk,
  // line drive
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sync_en = 1'b0;
  logic last_sclk = 1'b1;
  logic [7:0] sbyte = 8'h00;
  int idx = 0;
  initial o_line = 1'b1;
  // async frame, lsb first
  task automatic send(input logic [10:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      o_line <= f[i];
      repeat (bc) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask
  task automatic shift_in(input logic [7:0] b);
    sbyte = b;
    idx = 0;
    sync_en = 1'b1;
  endtask
  // new bit after clock falls, release after eighth rise
  always @(posedge i_clk) begin
    last_sclk <= i_sclk;
    if (sync_en && last_sclk && !i_sclk && idx < 8) begin
      o_line <= sbyte[idx];
      idx <= idx + 1;
    end else if (sync_en && !last_sclk && i_sclk && idx == 8) begin
      o_line <= 1'b1;
      sync_en <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== tb.sv
// testbench for the serial port
// assumes the remote model on the pins, bus master here
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED t=%0t got %0h exp %0h", \
  $time, g, e); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] m;
    logic b8;
    logic [7:0] dv;
    logic [7:0] d;
    logic rb;
  } row_s;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, rxd, rxd_out, rxd_oe, txd, irq, line;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  row_s rows [4] = '{'{2'h1, 1'b0, 8'h01, 8'hA5, 1'b1},
    '{2'h2, 1'b1, 8'h05, 8'h3C, 1'b1},
    '{2'h2, 1'b0, 8'h00, 8'hC3, 1'b0},
    '{2'h0, 1'b0, 8'h00, 8'h96, 1'b0}};
  assign rxd = rxd_oe ? rxd_out : line;

  uart_serial uart_serial_inst (
    .I_REF_CLK(clk), .I_ARST_N(arst_n), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_RXD(rxd), .O_RXD_OUT(rxd_out), .O_RXD_OE(rxd_oe),
    .O_TXD(txd), .O_SERIAL_RECEIVE_IRQ_LINE(irq)
  );
  uart_remote uart_remote_inst (.i_clk(clk), .i_sclk(txd), .o_line(line));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("CHECK FAILED t=%0t timeout", $time);
      test_done;
    end
  end

  // one single transfer, address then data phase
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  initial begin
    row_s w;
    int bc, n;
    logic [7:0] q, c;
    logic [10:0] f, e;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      w = rows[r];
      bc = (w.m == 2'h2) ? 16 : 16 * (w.dv + 1);
      c = {w.m, 2'b00, w.b8, 3'b010};
      wr(uart_pkg::CTRL_IDX, c);
      wr(uart_pkg::BAUD_IDX, w.dv);
      wr(uart_pkg::DATA_IDX, w.d);
      if (w.m == 2'h0) begin
        for (int i = 0; i < 8; i++) begin
          @(posedge txd);
          q[i] = rxd_out;
        end
        `CHK(q, w.d)
      end else begin
        @(negedge txd);
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
          f[i] = txd;
          repeat (bc) @(posedge clk);
        end
        e = (w.m == 2'h1) ? {2'b11, w.d, 1'b0} : {1'b1, w.b8, w.d, 1'b0};
        `CHK(f, e)
      end
      repeat (bc) @(posedge clk);
      `CHK(rxd_oe, 1'b0)
      bus(1'b0, uart_pkg::FLAG_IDX, 8'h00, q);
      `CHK(q[uart_pkg::TIP_BIT], 1'b1)
      wr(uart_pkg::FLAG_IDX, 8'h00);
      if (w.m == 2'h0) uart_remote_inst.shift_in(~w.d);
      wr(uart_pkg::CTRL_IDX, c | 8'h10);
      e = {1'b1, (w.m == 2'h1) | w.b8, ~w.d, 1'b0};
      if (w.m != 2'h0) uart_remote_inst.send(e, 10 + w.m[1], bc);
      n = 0;
      while (irq !== 1'b1 && n < 40 * bc) begin
        @(posedge clk);
        n++;
      end
      `CHK(irq, 1'b1)
      bus(1'b0, uart_pkg::DATA_IDX, 8'h00, q);
      `CHK(q, ~w.d)
      bus(1'b0, uart_pkg::CTRL_IDX, 8'h00, q);
      if (w.m != 2'h0) `CHK(q[uart_pkg::RB8_BIT], w.rb)
      $display("row %0d done", r);
    end
    repeat (48) @(posedge clk);
    `CHK(txd, 1'b1)
    wr(uart_pkg::CTRL_IDX, 8'h10);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("pending and mask test done");
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    `CHK(txd, 1'b1)
    wr(8'h00, 8'hFF);
    foreach (rows[i]) begin
      bus(1'b0, uart_pkg::CTRL_IDX + 8'(i), 8'h00, q);
      `CHK(q, 8'h00)
    end
    bus(1'b0, 8'h00, 8'h00, q);
    `CHK(q, 8'h00)
    $display("reset test done");
    test_done;
  end
endmodule

`default_nettype wire
